// *** logic/clk_cfg_pkg.sv ***
package clk_cfg_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_SOURCE_PLL  = 8'h34;
    localparam logic [7:0] OFS_RATIO_HIGH  = 8'h35;
    localparam logic [7:0] OFS_RATIO_LOW   = 8'h36;
    localparam logic [7:0] OFS_ROLE_FREQ   = 8'h37;

    // Reset values
    localparam logic [7:0] RST_SOURCE_PLL  = 8'h40;
    localparam logic [7:0] RST_RATIO_HIGH  = 8'h00;
    localparam logic [7:0] RST_RATIO_LOW   = 8'h00;
    localparam logic [7:0] RST_ROLE_FREQ   = 8'h20;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;

    // Field positions in the source / PLL register
    localparam int BIT_PLL_OFF      = 7;
    localparam int BIT_FRAC_PERMIT  = 6;
    localparam int SRC_HI           = 3;
    localparam int SRC_LO           = 1;
    localparam int BIT_RATIO_EDGE   = 0;

    // Ratio fields
    localparam int RATIO_W          = 14;
    localparam int RATIO_UPPER_HI   = 5;
    localparam logic [13:0] RATIO_AUTO = 14'h0000;

    // Fields in the role / frequency register
    localparam int FREQ_HI          = 7;
    localparam int FREQ_LO          = 5;
    localparam int BIT_PRIMARY_CTRL = 4;
    localparam int BIT_SECOND_CTRL  = 3;
    localparam int BIT_RATE_FAMILY  = 0;

    // Input clock source codes
    typedef enum logic [2:0] {
        SRC_PRIMARY_BCLK   = 3'h0,
        SRC_REF_PRIMARY_FS = 3'h1,
        SRC_SECOND_BCLK    = 3'h2,
        SRC_REF_SECOND_FS  = 3'h3,
        SRC_REF_FIXED      = 3'h4,
        SRC_INT_OSC        = 3'h5,
        SRC_RSVD6          = 3'h6,
        SRC_RSVD7          = 3'h7
    } clk_src_e;

    localparam int FREQ_KHZ_W = 15;

    // Reference frequency code to kHz
    function automatic logic [14:0] ref_freq_khz(input logic [2:0] code);
        unique case (code)
            3'h0: ref_freq_khz = 15'h2ee0; // 12000
            3'h1: ref_freq_khz = 15'h3000; // 12288
            3'h2: ref_freq_khz = 15'h32c8; // 13000
            3'h3: ref_freq_khz = 15'h3e80; // 16000
            3'h4: ref_freq_khz = 15'h4b00; // 19200
            3'h5: ref_freq_khz = 15'h4ce0; // 19680
            3'h6: ref_freq_khz = 15'h5dc0; // 24000
            3'h7: ref_freq_khz = 15'h6000; // 24576
        endcase
    endfunction

endpackage

// *** logic/audio_clock_source_config.sv ***
`timescale 1ns/1ps
// Function
// - PLL off bit disables PLL; else manual keeps it on, auto follows load.
// - Fractional PLL only while permit bit set; otherwise integer only.
// - Source field selects input clock; codes 6 and 7 reserved.
// - Code 4 uses fixed reference; valid only with a controller port.
// - Ratio edge bit: zero rising, one falling edge of clock source.
// - Ratio is lower six bits of high register above eight of low register.
// - Ratio zero means auto detection; 1 to 16383 used directly.
// - Reference frequency code maps to 12 up to 24.576 MHz.
// - Primary port bit four: zero target, one controller.
// - Secondary port bit three: zero target, one controller.
// - Bit zero picks 48 kHz or 44.1 kHz rate family.
// - Source register at 0x34 resets to 0x40.
// - Separate manual setup input selects manual or automatic clocking.
module audio_clock_source_config
    import clk_cfg_pkg::*;
(
    input  wire logic                  clk,              // 125 MHz clock
    input  wire logic                  srst,             // Sync reset
    input  wire logic [ADDR_W-1:0]     reg_addr,         // Register offset
    input  wire logic [DATA_W-1:0]     reg_wdata,        // Write data
    input  wire logic                  reg_write,        // Write strobe
    input  wire logic                  reg_read,         // Read strobe
    input  wire logic                  manual_setup,     // 1 manual clocking
    input  wire logic                  load_needs_pll,   // Auto PLL demand
    input  wire logic                  reconfig,         // Apply settings
    output logic [DATA_W-1:0]          reg_rdata_q,      // Read data
    output logic                       pll_enable_q,     // PLL running
    output logic                       pll_fractional_q, // Fractional allowed
    output logic [2:0]                 clock_source_q,   // Applied source
    output logic                       source_invalid_q, // Reserved/misused
    output logic                       ratio_edge_fall_q,// Falling edge
    output logic [RATIO_W-1:0]         ratio_value_q,    // Ratio value
    output logic                       ratio_auto_q,     // Auto detect
    output logic [FREQ_KHZ_W-1:0]      ref_freq_khz_q,   // Ref freq kHz
    output logic                       primary_ctrl_q,   // Primary controller
    output logic                       secondary_ctrl_q, // Second controller
    output logic                       rate_family_q     // 1 means 44.1 kHz
);

    logic [7:0] src_pll_q;
    logic [7:0] ratio_hi_q;
    logic [7:0] ratio_lo_q;
    logic [7:0] role_freq_q;
    logic [RATIO_W-1:0] ratio_d;
    logic               any_ctrl_d;
    logic [2:0]         src_d;

    always_comb begin
        ratio_d    = {ratio_hi_q[RATIO_UPPER_HI:0], ratio_lo_q};
        src_d      = src_pll_q[SRC_HI:SRC_LO];
        any_ctrl_d = role_freq_q[BIT_PRIMARY_CTRL] |
                     role_freq_q[BIT_SECOND_CTRL];
    end

    // Register store: full bytes kept so every field reads back
    always_ff @(posedge clk) begin
        if (srst) begin
            src_pll_q   <= RST_SOURCE_PLL;
            ratio_hi_q  <= RST_RATIO_HIGH;
            ratio_lo_q  <= RST_RATIO_LOW;
            role_freq_q <= RST_ROLE_FREQ;
        end else if (reg_write) begin
            unique case (reg_addr)
                OFS_SOURCE_PLL: src_pll_q   <= reg_wdata;
                OFS_RATIO_HIGH: ratio_hi_q  <= reg_wdata;
                OFS_RATIO_LOW:  ratio_lo_q  <= reg_wdata;
                OFS_ROLE_FREQ:  role_freq_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Read port, one cycle latency
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata_q <= UNMAPPED_READ;
        end else if (reg_read) begin
            unique case (reg_addr)
                OFS_SOURCE_PLL: reg_rdata_q <= src_pll_q;
                OFS_RATIO_HIGH: reg_rdata_q <= ratio_hi_q;
                OFS_RATIO_LOW:  reg_rdata_q <= ratio_lo_q;
                OFS_ROLE_FREQ:  reg_rdata_q <= role_freq_q;
                default:        reg_rdata_q <= UNMAPPED_READ;
            endcase
        end
    end

    // PLL control follows live state every cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            pll_enable_q     <= 1'b0;
            pll_fractional_q <= 1'b0;
        end else begin
            pll_enable_q <= !src_pll_q[BIT_PLL_OFF] &&
                            (manual_setup || load_needs_pll);
            pll_fractional_q <= !src_pll_q[BIT_PLL_OFF] &&
                                src_pll_q[BIT_FRAC_PERMIT];
        end
    end

    // Clocking selections applied only on reconfiguration
    always_ff @(posedge clk) begin
        if (srst) begin
            clock_source_q    <= SRC_PRIMARY_BCLK;
            source_invalid_q  <= 1'b0;
            ratio_edge_fall_q <= 1'b0;
            ratio_value_q     <= RATIO_AUTO;
            ratio_auto_q      <= 1'b1;
            ref_freq_khz_q    <= ref_freq_khz(RST_ROLE_FREQ[FREQ_HI:FREQ_LO]);
            primary_ctrl_q    <= 1'b0;
            secondary_ctrl_q  <= 1'b0;
            rate_family_q     <= 1'b0;
        end else if (reconfig) begin
            clock_source_q    <= src_d;
            source_invalid_q  <= (src_d == SRC_RSVD6) ||
                                 (src_d == SRC_RSVD7) ||
                                 ((src_d == SRC_REF_FIXED) &&
                                  !any_ctrl_d);
            ratio_edge_fall_q <= src_pll_q[BIT_RATIO_EDGE];
            ratio_value_q     <= ratio_d;
            ratio_auto_q      <= (ratio_d == RATIO_AUTO);
            ref_freq_khz_q    <=
                ref_freq_khz(role_freq_q[FREQ_HI:FREQ_LO]);
            primary_ctrl_q    <= role_freq_q[BIT_PRIMARY_CTRL];
            secondary_ctrl_q  <= role_freq_q[BIT_SECOND_CTRL];
            rate_family_q     <= role_freq_q[BIT_RATE_FAMILY];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_write_src;
        reg_write && reg_addr == OFS_SOURCE_PLL;
    endsequence

    sequence s_read_src;
        reg_read && !reg_write && reg_addr == OFS_SOURCE_PLL;
    endsequence

    a_pll_off_holds: assert property (
        src_pll_q[BIT_PLL_OFF] |=> !pll_enable_q)
        else $error("PLL enabled while off bit set");

    a_pll_manual_on: assert property (
        !src_pll_q[BIT_PLL_OFF] && manual_setup |=> pll_enable_q)
        else $error("PLL not running in manual setup");

    a_frac_permit: assert property (
        pll_fractional_q |-> $past(src_pll_q[BIT_FRAC_PERMIT]))
        else $error("Fractional PLL without permit");

    a_source_apply: assert property (
        reconfig |=> clock_source_q == $past(src_d))
        else $error("Source not applied on reconfiguration");

    a_fixed_ref_check: assert property (
        reconfig && src_d == SRC_REF_FIXED && !any_ctrl_d
        |=> source_invalid_q)
        else $error("Fixed reference without controller not flagged");

    a_ratio_auto: assert property (
        reconfig |=> ratio_auto_q == (ratio_value_q == RATIO_AUTO))
        else $error("Auto ratio flag mismatch");

    a_ratio_form: assert property (
        reconfig ##1 !reconfig |->
        ratio_value_q[7:0] == $past(ratio_lo_q))
        else $error("Ratio low byte wrong");

    a_roles_hold: assert property (
        !reconfig |=> $stable(primary_ctrl_q) && $stable(secondary_ctrl_q)
                      && $stable(rate_family_q))
        else $error("Role changed without reconfiguration");

    a_readback_src: assert property (
        s_write_src ##1 s_read_src |=> reg_rdata_q == $past(reg_wdata, 2))
        else $error("Source register read back wrong");

    a_reset_value: assert property (
        $past(srst) |-> src_pll_q == RST_SOURCE_PLL)
        else $error("Source register reset value wrong");

    a_pll_auto_load: assert property (
        !src_pll_q[BIT_PLL_OFF] && !manual_setup
        |=> pll_enable_q == $past(load_needs_pll))
        else $error("PLL not following load demand");

    a_frac_follow: assert property (
        !src_pll_q[BIT_PLL_OFF] && src_pll_q[BIT_FRAC_PERMIT]
        |=> pll_fractional_q)
        else $error("Fractional PLL not allowed with permit");

    a_reserved_flag: assert property (
        reconfig && (src_d == SRC_RSVD6 || src_d == SRC_RSVD7)
        |=> source_invalid_q)
        else $error("Reserved source code not flagged");

    a_fixed_ref_ok: assert property (
        reconfig && src_d == SRC_REF_FIXED && any_ctrl_d
        |=> !source_invalid_q)
        else $error("Fixed reference with controller flagged");

    a_edge_apply: assert property (
        reconfig |=> ratio_edge_fall_q == $past(src_pll_q[BIT_RATIO_EDGE]))
        else $error("Ratio edge not applied");

    a_ratio_upper: assert property (
        reconfig |=> ratio_value_q[RATIO_W-1:DATA_W] ==
                     $past(ratio_hi_q[RATIO_UPPER_HI:0]))
        else $error("Ratio upper bits wrong");

    a_freq_apply: assert property (
        reconfig |=> ref_freq_khz_q ==
                     ref_freq_khz($past(role_freq_q[FREQ_HI:FREQ_LO])))
        else $error("Reference frequency not applied");

    a_roles_apply: assert property (
        reconfig |=> primary_ctrl_q == $past(role_freq_q[BIT_PRIMARY_CTRL])
                     && secondary_ctrl_q ==
                        $past(role_freq_q[BIT_SECOND_CTRL]))
        else $error("Port roles not applied");

    a_rate_apply: assert property (
        reconfig |=> rate_family_q == $past(role_freq_q[BIT_RATE_FAMILY]))
        else $error("Rate family not applied");

    a_source_hold: assert property (
        !reconfig |=> $stable(clock_source_q) && $stable(ratio_value_q)
                      && $stable(ref_freq_khz_q))
        else $error("Applied source changed without reconfiguration");

endmodule

// *** sim/pll_demand_host.sv ***
`timescale 1ns/1ps
module pll_demand_host (
    input  wire logic       clk,                   // Bench clock
    input  wire logic [1:0] mode,                  // Manual and load levels
    output logic            manual_setup = 1'b0,   // Manual clock setup
    output logic            load_needs_pll = 1'b0  // Load asks for PLL
);
    // Levels move at the falling edge, clear of the sampling edge
    always @(negedge clk) begin
        manual_setup   <= mode[1];
        load_needs_pll <= mode[0];
    end
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import clk_cfg_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        reconfig = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic        manual_setup, load_needs_pll, pll_enable_q;
    logic        pll_fractional_q, source_invalid_q, ratio_edge_fall_q;
    logic        ratio_auto_q, primary_ctrl_q, secondary_ctrl_q;
    logic        rate_family_q, rd_seen, pri, sec;
    logic [7:0]  reg_rdata_q, d;
    logic [2:0]  clock_source_q;
    logic [13:0] ratio_value_q, rv;
    logic [14:0] ref_freq_khz_q;
    logic [14:0] freq_tbl [8] = '{15'h2ee0, 15'h3000, 15'h32c8,
        15'h3e80, 15'h4b00, 15'h4ce0, 15'h5dc0, 15'h6000};
    logic [7:0]  exp_q [$];
    int          num_errors = 0;
    int          n_tests = 0;

    audio_clock_source_config audio_clock_source_config_inst (
        .clk              (clk),
        .srst             (srst),
        .reg_addr         (reg_addr),
        .reg_wdata        (reg_wdata),
        .reg_write        (reg_write),
        .reg_read         (reg_read),
        .manual_setup     (manual_setup),
        .load_needs_pll   (load_needs_pll),
        .reconfig         (reconfig),
        .reg_rdata_q      (reg_rdata_q),
        .pll_enable_q     (pll_enable_q),
        .pll_fractional_q (pll_fractional_q),
        .clock_source_q   (clock_source_q),
        .source_invalid_q (source_invalid_q),
        .ratio_edge_fall_q(ratio_edge_fall_q),
        .ratio_value_q    (ratio_value_q),
        .ratio_auto_q     (ratio_auto_q),
        .ref_freq_khz_q   (ref_freq_khz_q),
        .primary_ctrl_q   (primary_ctrl_q),
        .secondary_ctrl_q (secondary_ctrl_q),
        .rate_family_q    (rate_family_q)
    );
    pll_demand_host pll_demand_host_inst (.clk, .mode, .manual_setup,
        .load_needs_pll);

    always #4 clk = ~clk;

    task automatic chk(input logic [14:0] g, input logic [14:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        reg_read = 1'b0;
    endtask

    // Write then read the same offset on the very next edge
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        reg_read = 1'b1;
        exp_q.push_back(v);
        @(negedge clk);
        reg_read = 1'b0;
    endtask

    task automatic apply;
        @(negedge clk);
        reconfig = 1'b1;
        @(negedge clk);
        reconfig = 1'b0;
        @(negedge clk);
    endtask

    task automatic report_and_stop;
        $display("Checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Read data is checked against the oldest note once it lands
    always @(posedge clk) rd_seen <= reg_read & ~srst;
    always @(negedge clk) begin
        if (rd_seen) chk(reg_rdata_q, exp_q.pop_front());
    end

    initial begin
        #20000;
        num_errors++;
        report_and_stop;
    end

    initial begin
        void'($urandom(32'hf303));
        repeat (8) @(negedge clk);
        srst = 1'b0;
        rd(8'h34, 8'h40);
        rd(8'h35, 8'h00);
        rd(8'h36, 8'h00);
        rd(8'h37, 8'h20);
        rd(8'h50, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            if (i == 1) d[7:6] = 2'b00;
            wr(8'(8'h34 + i), d);
            rd(8'(8'h34 + i), d);
        end
        for (int m = 0; m < 16; m++) begin
            mode <= m[1:0];
            wr(8'h34, {m[3], m[2], 6'h00});
            repeat (3) @(negedge clk);
            chk(pll_enable_q, !m[3] && (m[1] || m[0]));
            chk(pll_fractional_q, !m[3] && m[2]);
        end
        for (int i = 0; i < 8; i++) begin
            rv = 14'($urandom);
            if (i == 0) rv = 14'h0000;
            if (i == 7) rv = 14'h3fff;
            pri = i[1];
            sec = i[1] & i[0];
            wr(8'h34, {4'h4, i[2:0], i[0]});
            wr(8'h35, {2'b00, rv[13:8]});
            wr(8'h36, rv[7:0]);
            wr(8'h37, {i[2:0], pri, sec, 2'b00, i[2]});
            apply;
            chk(clock_source_q, i[2:0]);
            chk(source_invalid_q, i > 5 || (i == 4 && !pri));
            chk(ratio_edge_fall_q, i[0]);
            chk(ratio_value_q, rv);
            chk(ratio_auto_q, rv == 14'h0000);
            chk(ref_freq_khz_q, freq_tbl[i]);
            chk(primary_ctrl_q, pri);
            chk(secondary_ctrl_q, sec);
            chk(rate_family_q, i[2]);
        end
        d = 8'($urandom);
        wr_rd(8'h34, d);
        wr(8'h37, 8'h10);
        wr(8'h34, 8'h48);
        apply;
        chk(source_invalid_q, 1'b0);
        chk(ref_freq_khz_q, freq_tbl[0]);
        wr(8'h37, 8'h00);
        repeat (3) @(negedge clk);
        chk(primary_ctrl_q, 1'b1);
        @(negedge clk);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        chk(ratio_auto_q, 1'b1);
        chk(ref_freq_khz_q, freq_tbl[1]);
        chk(primary_ctrl_q, 1'b0);
        rd(8'h34, 8'h40);
        report_and_stop;
    end
endmodule
